// ---- src/sir_codec_pkg.sv ----
// constants and types shared by the infrared pulse encoder and decoder
`default_nettype none

package sir_codec_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_PERIOD_PS = 5000;  // sys_clk at 200 MHz
  localparam int unsigned MIN_PULSE_PS = 1600000;  // 1.6 us least optical pulse
  // least time rounds up to whole sys_clk cycles
  localparam int unsigned MIN_PULSE_CYCLES =
    (MIN_PULSE_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int unsigned LIT_CNT_W = 9;  // holds MIN_PULSE_CYCLES

  // ----------------------------------------------------------------
  // bit cell layout, in bit_clock_x16 periods
  // ----------------------------------------------------------------
  localparam int unsigned CELL_CLOCKS = 16;
  localparam logic [3:0] ENC_RISE_CNT = 4'h6;  // 7th falling edge of the cell
  localparam logic [3:0] ENC_FALL_CNT = 4'h9;  // 10th falling edge of the cell
  localparam logic [3:0] DEC_LOW_LAST = 4'hF;  // 16 rising edges of low output

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic SYNC_RESET = 1'b1;  // receive line idles high
  localparam logic TX_OUT_RESET = 1'b0;
  localparam logic RX_OUT_RESET = 1'b1;

  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ENC_IDLE = 2'b00,  // serial line high, counter cleared
    ENC_WAIT = 2'b01,  // serial line low, optical output dark
    ENC_LIT = 2'b10,  // optical pulse on
    ENC_HOLD = 2'b11  // pulse stretched to the least width
  } enc_state_t;

  typedef enum logic {
    DEC_HIGH = 1'b0,
    DEC_LOW = 1'b1
  } dec_state_t;

endpackage : sir_codec_pkg

`default_nettype wire

// ---- src/sir_rx_decoder.sv ----
// receive side: turns detected optical falling edges into 16-clock lows
`default_nettype none

module sir_rx_decoder (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // ticks from the top level
  input wire logic rise_tick,
  input wire logic rx_fall,
  // decoded serial data to the uart
  output logic serial_rx_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    sir_codec_pkg::dec_state_t state;
    logic pend;
    logic [3:0] cnt;
    logic out;
  } dec_reg_t;

  dec_reg_t st_ff;
  dec_reg_t nxt_st;
  logic go;

  // an edge waits for the next x16 rising edge; a new edge beats the clear
  always_comb begin
    nxt_st = st_ff;
    go = rise_tick && (st_ff.pend || rx_fall);
    nxt_st.pend = (st_ff.pend || rx_fall) && !rise_tick;
    case (st_ff.state)
      sir_codec_pkg::DEC_HIGH: begin
        // without an edge the output simply stays high
        if (go) begin
          nxt_st.state = sir_codec_pkg::DEC_LOW;
          nxt_st.cnt = sir_codec_pkg::CNT_RESET;
          nxt_st.out = 1'b0;
        end
      end
      sir_codec_pkg::DEC_LOW: begin
        if (go) begin
          nxt_st.cnt = sir_codec_pkg::CNT_RESET;  // next zero restarts the low
        end else if (rise_tick) begin
          if (st_ff.cnt == sir_codec_pkg::DEC_LOW_LAST) begin
            // a late edge lands after this, giving a one-clock high
            nxt_st.state = sir_codec_pkg::DEC_HIGH;
            nxt_st.out = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt + 4'h1;
          end
        end
      end
      default: begin
        nxt_st.state = sir_codec_pkg::DEC_HIGH;
        nxt_st.out = 1'b1;
      end
    endcase
  end

  // registered state, reset drives output high and clears the counter
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff.state <= sir_codec_pkg::DEC_HIGH;
      st_ff.pend <= 1'b0;
      st_ff.cnt <= sir_codec_pkg::CNT_RESET;
      st_ff.out <= sir_codec_pkg::RX_OUT_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign serial_rx_out = st_ff.out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_reset_state: assert property ($fell(srst) |-> (serial_rx_out && st_ff.cnt == 4'h0))
    else $error("decoder not cleared by reset");
  a_low_on_tick: assert property ((st_ff.pend || rx_fall) && rise_tick |=> !serial_rx_out)
    else $error("decoded output not low after edge and tick");
  a_low_release: assert property (
      st_ff.state == sir_codec_pkg::DEC_LOW && st_ff.cnt == 4'hF && rise_tick
      && !st_ff.pend && !rx_fall |=> serial_rx_out)
    else $error("decoded output not high after sixteen clocks");
  a_high_quiet: assert property (serial_rx_out && !st_ff.pend && !rx_fall |=> serial_rx_out)
    else $error("decoded output fell without an edge");
  a_low_holds: assert property ($fell(serial_rx_out) |-> st_ff.cnt == 4'h0 ##1 !serial_rx_out)
    else $error("decoded low too short");

  c_zero_bit: cover property ($fell(serial_rx_out));
  c_one_clock_high: cover property ($rose(serial_rx_out) ##[1:300] $fell(serial_rx_out));

endmodule : sir_rx_decoder

`default_nettype wire

// ---- src/sir_pulse_encoder_decoder.sv ----
// serial infrared pulse encoder and decoder between a uart and an optical transceiver
//
// Notes on behaviour
// - one x16 bit clock paces both transmit pulses and receive sampling
// - a one is a sixteen-clock cell with no optical pulse
// - a zero is exactly one optical pulse in its sixteen-clock cell
// - start, data and stop bits are handled alike, no framing kept
// - only the lowest-rate scheme; any slower matching rate also works
// - each pulse not cut short by serial input rising lasts at least 1.6 us and three bit clocks
// - serial input high keeps optical output low and counter cleared
// - output rises on seventh falling bit clock, falls on the tenth
// - while serial input stays low, pulse repeats in every cell
// - reset drives decoded output high and clears its four-bit counter
// - optical falling edge drives decoded output low at next rising clock
// - decoded output stays low sixteen clocks, then returns high
// - with no optical falling edges the decoded output stays high
// - an edge late by one clock leaves a one-clock high pulse
// - positive optical pulses also decode, at their trailing edge
// - active-high reset starts both encoder and decoder afresh
`default_nettype none

module sir_pulse_encoder_decoder #(
  parameter int unsigned MIN_PULSE_CYC = sir_codec_pkg::MIN_PULSE_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // bit rate clock, sixteen times the baud rate
  input wire logic bit_clock_x16,
  // uart side
  input wire logic serial_tx_in,
  output logic serial_rx_out,
  // optical transceiver side
  input wire logic optical_rx_in,
  output logic optical_tx_out
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  localparam int unsigned LIT_MAX = (1 << sir_codec_pkg::LIT_CNT_W) - 1;

  if (MIN_PULSE_CYC < 1 || MIN_PULSE_CYC > LIT_MAX) begin : g_bad_min_pulse
    $error("MIN_PULSE_CYC out of range for the width counter");
  end

  localparam logic [sir_codec_pkg::LIT_CNT_W-1:0] LIT_LAST =
    sir_codec_pkg::LIT_CNT_W'(MIN_PULSE_CYC - 1);
  localparam logic [sir_codec_pkg::LIT_CNT_W-1:0] LIT_SAT =
    sir_codec_pkg::LIT_CNT_W'(LIT_MAX);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bclk_s1;
    logic bclk_s2;
    logic bclk_s3;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    sir_codec_pkg::enc_state_t enc_state;
    logic [3:0] enc_cnt;
    logic [sir_codec_pkg::LIT_CNT_W-1:0] lit_cnt;
    logic tx_out;
  } top_reg_t;

  top_reg_t st_ff;
  top_reg_t nxt_st;

  // ticks and edges seen on the synchronised inputs
  logic rise_tick;
  logic fall_tick;
  logic rx_fall;
  logic lit_done;

  // edge detect reads only the second and third stages; any slower bit clock works
  assign rise_tick = st_ff.bclk_s2 && !st_ff.bclk_s3;
  assign fall_tick = !st_ff.bclk_s2 && st_ff.bclk_s3;
  // falling edges only: a positive pulse is caught at its trailing edge
  assign rx_fall = !st_ff.rx_s2 && st_ff.rx_s3;
  // the least width is honoured even if the bit clock runs too fast
  assign lit_done = st_ff.lit_cnt >= LIT_LAST;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // the bit clock is treated as a sampled input, not a clock domain, so
  // its edges lag by two sys_clk cycles; negligible at 16x baud rates
  always_comb begin
    nxt_st = st_ff;
    nxt_st.bclk_s1 = bit_clock_x16;
    nxt_st.bclk_s2 = st_ff.bclk_s1;
    nxt_st.bclk_s3 = st_ff.bclk_s2;
    nxt_st.rx_s1 = optical_rx_in;
    nxt_st.rx_s2 = st_ff.rx_s1;
    nxt_st.rx_s3 = st_ff.rx_s2;

    if (serial_tx_in) begin
      // a one: no light and the cell counter held at zero
      nxt_st.enc_state = sir_codec_pkg::ENC_IDLE;
      nxt_st.enc_cnt = sir_codec_pkg::CNT_RESET;
      nxt_st.lit_cnt = '0;
      nxt_st.tx_out = 1'b0;
    end else begin
      // each bit is handled on its own, framing is the uart's business
      if (fall_tick) begin
        nxt_st.enc_cnt = st_ff.enc_cnt + 4'h1;
      end
      case (st_ff.enc_state)
        sir_codec_pkg::ENC_IDLE,
        sir_codec_pkg::ENC_WAIT: begin
          nxt_st.enc_state = sir_codec_pkg::ENC_WAIT;
          if (fall_tick && st_ff.enc_cnt == sir_codec_pkg::ENC_RISE_CNT) begin
            nxt_st.enc_state = sir_codec_pkg::ENC_LIT;
            nxt_st.tx_out = 1'b1;
            nxt_st.lit_cnt = '0;
          end
        end
        sir_codec_pkg::ENC_LIT: begin
          if (st_ff.lit_cnt != LIT_SAT) begin
            nxt_st.lit_cnt = st_ff.lit_cnt + 1'b1;
          end
          if (fall_tick && st_ff.enc_cnt == sir_codec_pkg::ENC_FALL_CNT) begin
            if (lit_done) begin
              nxt_st.enc_state = sir_codec_pkg::ENC_WAIT;
              nxt_st.tx_out = 1'b0;
            end else begin
              nxt_st.enc_state = sir_codec_pkg::ENC_HOLD;
            end
          end
        end
        sir_codec_pkg::ENC_HOLD: begin
          if (st_ff.lit_cnt != LIT_SAT) begin
            nxt_st.lit_cnt = st_ff.lit_cnt + 1'b1;
          end
          if (lit_done) begin
            nxt_st.enc_state = sir_codec_pkg::ENC_WAIT;
            nxt_st.tx_out = 1'b0;
          end
        end
        default: begin
          nxt_st.enc_state = sir_codec_pkg::ENC_IDLE;
          nxt_st.tx_out = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // synchronous reset loads constants only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff.bclk_s1 <= 1'b0;
      st_ff.bclk_s2 <= 1'b0;
      st_ff.bclk_s3 <= 1'b0;
      st_ff.rx_s1 <= sir_codec_pkg::SYNC_RESET;
      st_ff.rx_s2 <= sir_codec_pkg::SYNC_RESET;
      st_ff.rx_s3 <= sir_codec_pkg::SYNC_RESET;
      st_ff.enc_state <= sir_codec_pkg::ENC_IDLE;
      st_ff.enc_cnt <= sir_codec_pkg::CNT_RESET;
      st_ff.lit_cnt <= '0;
      st_ff.tx_out <= sir_codec_pkg::TX_OUT_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign optical_tx_out = st_ff.tx_out;

  // ----------------------------------------------------------------
  // receive decoder
  // ----------------------------------------------------------------
  // decoding is per bit; mid-bit sampling by the uart hides the glitch
  sir_rx_decoder u_decoder (
    .sys_clk(sys_clk),
    .srst(srst),
    .rise_tick(rise_tick),
    .rx_fall(rx_fall),
    .serial_rx_out(serial_rx_out)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_tx_dark_high: assert property (serial_tx_in |=> !optical_tx_out)
    else $error("optical output lit while serial input high");
  a_cnt_cleared: assert property (serial_tx_in |=> st_ff.enc_cnt == 4'h0)
    else $error("cell counter not cleared while serial input high");
  a_rise_seventh: assert property (
      !serial_tx_in && fall_tick && st_ff.enc_cnt == 4'h6
      && st_ff.enc_state != sir_codec_pkg::ENC_LIT |=> optical_tx_out)
    else $error("pulse did not start on seventh falling bit clock");
  a_rise_cause: assert property ($rose(optical_tx_out) |-> $past(fall_tick)
      && $past(st_ff.enc_cnt) == 4'h6)
    else $error("pulse started at the wrong clock");
  a_fall_tenth: assert property (
      !serial_tx_in && fall_tick && st_ff.enc_cnt == 4'h9
      && st_ff.enc_state == sir_codec_pkg::ENC_LIT && lit_done |=> !optical_tx_out)
    else $error("pulse did not end on tenth falling bit clock");
  a_pulse_width: assert property ($fell(optical_tx_out) && !$past(serial_tx_in)
      |-> $past(st_ff.lit_cnt) >= LIT_LAST)
    else $error("optical pulse shorter than least width");
  a_pulse_window: assert property (optical_tx_out && st_ff.enc_state == sir_codec_pkg::ENC_LIT
      |-> st_ff.enc_cnt >= 4'h7 && st_ff.enc_cnt <= 4'h9)
    else $error("pulse outside clocks seven to ten of the cell");
  a_rx_sync: assert property (rx_fall |-> $past(optical_rx_in, 3) && !$past(optical_rx_in, 2))
    else $error("receive edge not delayed through synchroniser");

  c_tx_pulse: cover property ($rose(optical_tx_out) ##[1:1000] $fell(optical_tx_out));
  c_tx_repeat: cover property ($fell(optical_tx_out) ##[1:1000] $rose(optical_tx_out));
  c_rx_edge: cover property (rx_fall ##[1:300] !serial_rx_out);

endmodule : sir_pulse_encoder_decoder

`default_nettype wire

// ---- tb/optical_link_model.sv ----
// bit clock source and optical transceiver model facing the pulse codec
`default_nettype none

module optical_link_model #(
  parameter int unsigned HALF_CYC = 4
) (
  // clock
  input wire logic sys_clk,
  // bench controls
  input wire logic loop_en,
  input wire logic pulse_pos,
  input wire logic pulse_req,
  // codec pins
  input wire logic optical_tx_out,
  output logic bit_clock_x16,
  output logic optical_rx_in
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned div_cnt = 0;
  int unsigned lit_cnt = 0;

  // free running x16 clock: a uart baud output never stops
  always @(posedge sys_clk) begin
    div_cnt <= (div_cnt == 2 * HALF_CYC - 1) ? 0 : div_cnt + 1;
  end
  assign bit_clock_x16 = (div_cnt < HALF_CYC) ? 1'b1 : 1'b0;

  // a request lights the receiver for three bit clocks, 3/16 of a cell
  always @(posedge sys_clk) begin
    if (pulse_req)
      lit_cnt <= 6 * HALF_CYC;
    else if (lit_cnt != 0)
      lit_cnt <= lit_cnt - 1;
  end

  // inverting receivers idle high; loopback echoes the positive led pulse
  assign optical_rx_in = loop_en ? optical_tx_out : ((lit_cnt != 0) ~^ pulse_pos);
endmodule : optical_link_model

`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the infrared pulse encoder and decoder
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int BCP = 8;  // sys_clk cycles per bit clock
  localparam int CELL = 16 * BCP;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic serial_tx_in = 1'b1;
  logic loop_en = 1'b0;
  logic pulse_pos = 1'b0;
  logic pulse_req = 1'b0;
  logic bit_clock_x16;
  logic optical_rx_in;
  logic serial_rx_out;
  logic optical_tx_out;
  int fail_count = 0;
  int cmp_count = 0;

  // 200 MHz system clock
  always #2.5 sys_clk = ~sys_clk;

  // short least width so that three bit clocks set the pulse length
  sir_pulse_encoder_decoder #(.MIN_PULSE_CYC(4)) u_sir_pulse_encoder_decoder (
    .sys_clk(sys_clk), .srst(srst), .bit_clock_x16(bit_clock_x16),
    .serial_tx_in(serial_tx_in), .serial_rx_out(serial_rx_out),
    .optical_rx_in(optical_rx_in), .optical_tx_out(optical_tx_out));

  optical_link_model #(.HALF_CYC(BCP / 2)) u_optical_link_model (
    .sys_clk(sys_clk), .loop_en(loop_en), .pulse_pos(pulse_pos),
    .pulse_req(pulse_req), .optical_tx_out(optical_tx_out),
    .bit_clock_x16(bit_clock_x16), .optical_rx_in(optical_rx_in));

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic check_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_range(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("unexpected at %0t: got %0h expected %0h..%0h", $time, got, lo, hi);
    end
  endtask : check_range

  // counts edges until the watched output shows lvl; a spent bound ends the run
  task automatic wait_for(input bit rx, input logic lvl, input int bound, output int n);
    n = 0;
    while ((rx ? serial_rx_out : optical_tx_out) !== lvl) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > bound) begin
        fail_count++;
        print_verdict();
      end
    end
  endtask : wait_for

  task automatic hold_check(input bit rx, input logic lvl, input int cycles);
    for (int i = 0; i < cycles; i++) begin
      @(posedge sys_clk);
      #1;
      check_bit(rx ? serial_rx_out : optical_tx_out, lvl);
    end
  endtask : hold_check

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // pulse train, abort mid-pulse, dark ones, then a fresh start
  task automatic tx_pulse_train();
    int n;
    int w;
    for (int r = 0; r < 2; r++) begin
      @(posedge sys_clk) serial_tx_in <= 1'b0;
      wait_for(0, 1'b1, CELL, n);
      check_range(n, 6 * BCP, 7 * BCP + 6);
      for (int k = 0; k < 3; k++) begin
        wait_for(0, 1'b0, CELL, w);
        check_range(w, 3 * BCP, 3 * BCP);
        wait_for(0, 1'b1, CELL, n);
        check_range(n + w, CELL, CELL);
      end
      @(posedge sys_clk) serial_tx_in <= 1'b1;
      wait_for(0, 1'b0, 3, n);
      check_range(n, 1, 3);
      hold_check(0, 1'b0, 2 * CELL);
    end
  endtask : tx_pulse_train

  // two negative pulses, the second one bit clock late
  task automatic rx_negative();
    int n;
    @(posedge sys_clk) pulse_req <= 1'b1;
    fork
      begin
        repeat (17 * BCP) @(posedge sys_clk);
        pulse_req <= 1'b1;
        @(posedge sys_clk) pulse_req <= 1'b0;
      end
    join_none
    @(posedge sys_clk) pulse_req <= 1'b0;
    wait_for(1, 1'b0, 2 * BCP, n);
    check_range(n, 3, BCP + 2);
    wait_for(1, 1'b1, CELL + 2, n);
    check_range(n, CELL, CELL);
    wait_for(1, 1'b0, 2 * BCP, n);
    check_range(n, BCP, BCP);
    wait_for(1, 1'b1, CELL + 2, n);
    check_range(n, CELL, CELL);
    hold_check(1, 1'b1, CELL);
  endtask : rx_negative

  // positive pulse decodes at its trailing edge; then a looped uart frame
  task automatic rx_positive_frame();
    int n;
    logic [9:0] frame;
    frame = {1'b1, 8'hA5, 1'b0};
    // idle low line gives one false zero, let it run out first
    @(posedge sys_clk) pulse_pos <= 1'b1;
    wait_for(1, 1'b0, 2 * BCP, n);
    wait_for(1, 1'b1, CELL + 2, n);
    @(posedge sys_clk) pulse_req <= 1'b1;
    @(posedge sys_clk) pulse_req <= 1'b0;
    wait_for(1, 1'b0, 5 * BCP, n);
    check_range(n, 3 * BCP + 3, 4 * BCP + 2);
    wait_for(1, 1'b1, CELL + 2, n);
    check_range(n, CELL, CELL);
    @(posedge sys_clk) loop_en <= 1'b1;
    fork
      for (int b = 0; b < 10; b++) begin
        @(posedge sys_clk) serial_tx_in <= frame[b];
        repeat (CELL - 1) @(posedge sys_clk);
      end
    join_none
    // uart strobe: eight bit clocks after the start edge, then every cell
    wait_for(1, 1'b0, 2 * CELL, n);
    repeat (8 * BCP) @(posedge sys_clk);
    #1;
    for (int b = 0; b < 10; b++) begin
      check_bit(serial_rx_out, frame[b]);
      repeat (CELL) @(posedge sys_clk);
      #1;
    end
  endtask : rx_positive_frame

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    check_bit(optical_tx_out, 1'b0);
    check_bit(serial_rx_out, 1'b1);
    @(posedge sys_clk) srst <= 1'b0;
    repeat (2 * CELL) @(posedge sys_clk);
    tx_pulse_train();
    rx_negative();
    rx_positive_frame();
    print_verdict();
  end
endmodule : tb

`default_nettype wire
